/* File: core/dtwt_pkg.sv */
// Constants for the dual basic timer and wake-up timer block.
// Assumes an 8-bit special-function register port and a secondary register space.
package dtwt_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_TCTRL   = 8'h88;
	localparam logic [7:0] ADDR_TMODE   = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW  = 8'h8a;
	localparam logic [7:0] ADDR_T1_LOW  = 8'h8b;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
	localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
	localparam logic [7:0] ADDR_WT_CFG  = 8'h93;
	localparam logic [7:0] ADDR_WT_SETH = 8'h94;
	localparam logic [7:0] ADDR_WT_SETL = 8'h95;
	localparam logic [7:0] ADDR_WT_PWR  = 8'h2d;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] RST_PWR    = 8'hff;
	localparam logic [7:0] TCTRL_RSVD = 8'h05;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int TC_TF1  = 7;
	localparam int TC_TR1  = 6;
	localparam int TC_TF0  = 5;
	localparam int TC_TR0  = 4;
	localparam int TC_EI1  = 3;
	localparam int TC_EI0  = 1;
	localparam int TM_M1LO = 4;
	localparam int TM_M0LO = 0;
	localparam int WC_EN   = 0;
	localparam int WC_RLD  = 1;
	localparam int WC_CSEL = 2;
	localparam int WC_STEP = 3;
	localparam int PW_CRYSTAL_CLOCK = 4;

	// ************************************************************
	// Modes and timing
	// ************************************************************
	localparam logic [1:0] MODE_13  = 2'h0;
	localparam logic [1:0] MODE_16  = 2'h1;
	localparam logic [1:0] MODE_RLD = 2'h2;
	localparam logic [1:0] MODE_SPL = 2'h3;
	localparam int         PRESC_DIV  = 12;
	localparam logic [3:0] PRESC_LAST = 4'(PRESC_DIV - 1);

endpackage

/* File: core/dtwt_timer.sv */
// Two 16-bit basic timers on the system clock divided by twelve, plus a 32-bit wake-up timer.
// Assumes register strobes, event pulses and the two slow clocks are synchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Mode 0 counts high byte plus low five.
// R2: Counting steps at clock/12, gated by run.
// R3: Mode 0 all ones wraps, sets overflow.
// R4: Mode 1 sixteen-bit wrap sets overflow.
// R5: Mode 2 reloads low from high.
// R6: Split: low byte uses timer zero; one holds.
// R7: Split: high byte uses timer one controls.
// R8: Split: timer one runs unless mode three.
// R9: Split: timer one overflow raises no flag.
// R10: Hardware sets overflow flags, split sets bit 7.
// R11: Hardware sets external flags; software clears.
// R12: Mode register holds two-bit fields.
// R13: Wake timer counts to setting, raises interrupt.
// R14: Wake clock selects crystal or RC.
// R15: Reload select and enable bits.
// R16: Period is setting plus one steps.
// R17: Step mode sits at config bit 3.
// R18: Setting or config write clears counter.
// R19: Wake flag wakes idle; software clears.
// R20: Single shot clears enable at completion.
// R21: Software enables last, stops before changes.
// R22: Reload and overflow flag same cycle.
// R23: Wake flag stays until software clears.
module dtwt_timer
(
	input  wire logic       i_mclk,             // System clock, 10 MHz.
	input  wire logic       i_resetn,           // Asynchronous reset, active low.
	input  wire logic       i_sfr_sec,          // High selects the secondary register space.
	input  wire logic [7:0] i_sfr_addr,         // Register address.
	input  wire logic       i_sfr_wr,           // Write strobe.
	input  wire logic       i_sfr_rd,           // Read strobe.
	input  wire logic [7:0] i_sfr_wdata,        // Write data.
	output logic      [7:0] o_sfr_rdata,        // Read data, one cycle after the strobe.
	input  wire logic       i_ext_irq_zero_evt, // External interrupt zero event pulse.
	input  wire logic       i_ext_irq_one_evt,  // External interrupt one event pulse.
	input  wire logic       i_low_speed_rc_clock, // Slow RC clock level.
	input  wire logic       i_crystal_clock,    // Crystal clock level.
	input  wire logic       i_wake_flag_clr,    // Software clear of the wake flag.
	output logic            o_timer_zero_overflow_flag, // Timer zero overflow flag.
	output logic            o_timer_one_overflow_flag,  // Timer one overflow flag.
	output logic            o_ext_irq_zero_flag, // External interrupt zero flag.
	output logic            o_ext_irq_one_flag,  // External interrupt one flag.
	output logic            o_wake_timer_flag,  // Wake-up timer interrupt flag.
	output logic            o_wake_request,     // Wake request out of idle.
	output logic      [7:0] o_wake_timer_power_switches // Analog power switch bits.
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [3:0]  presc;
		logic [7:0]  tctrl;
		logic [1:0]  t0_mode;
		logic [1:0]  t1_mode;
		logic [7:0]  t0_low;
		logic [7:0]  t0_high;
		logic [7:0]  t1_low;
		logic [7:0]  t1_high;
		logic [3:0]  wt_cfg;
		logic [7:0]  wt_set_high;
		logic [7:0]  wt_set_low;
		logic [7:0]  wt_pwr;
		logic [31:0] wt_cnt;
		logic        wt_flag;
		logic        rc_last;
		logic        crystal_clock_last;
		logic [7:0]  rdata;
	} dtwt_state_s;

	dtwt_state_s state_reg;
	dtwt_state_s state_next;

	// ************************************************************
	// Basic timer step
	// ************************************************************
	// Returns {overflow, high byte, low byte} after one count in the given mode.
	function automatic logic [16:0] dtwt_step(input logic [1:0] mode, input logic [7:0] th, input logic [7:0] tl);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		s13 = {1'b0, th, tl[4:0]} + 14'h0001;
		s16 = {1'b0, th, tl} + 17'h0_0001;
		s8  = {1'b0, tl} + 9'h001;
		case (mode)
			dtwt_pkg::MODE_13:  dtwt_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]}; // R1 R3
			dtwt_pkg::MODE_16:  dtwt_step = s16; // R4
			dtwt_pkg::MODE_RLD: dtwt_step = s8[8] ? {1'b1, th, th} : {1'b0, th, s8[7:0]}; // R5 R22
			default:            dtwt_step = {s8[8], th, s8[7:0]}; // R6
		endcase
	endfunction

	// ************************************************************
	// Decode
	// ************************************************************
	logic        wr_main;
	logic        tick;
	logic        split;
	logic        t0_run;
	logic        t1_run;
	logic        th0_run;
	logic [16:0] t0_res;
	logic [16:0] t1_res;
	logic [8:0]  th0_res;
	logic        wt_tick;
	logic [31:0] wt_target;
	logic        wt_match;
	logic        wt_wr;
	logic        wr_t0;
	logic        wr_t1;
	logic        wr_tctrl;

	always_comb
	begin
		wr_main   = i_sfr_wr & ~i_sfr_sec;
		tick      = state_reg.presc == dtwt_pkg::PRESC_LAST; // R2
		split     = state_reg.t0_mode == dtwt_pkg::MODE_SPL;
		t0_run    = tick & state_reg.tctrl[dtwt_pkg::TC_TR0]; // R2 R6
		th0_run   = tick & split & state_reg.tctrl[dtwt_pkg::TC_TR1]; // R7
		t1_run    = tick & (state_reg.t1_mode != dtwt_pkg::MODE_SPL)
		            & (split | state_reg.tctrl[dtwt_pkg::TC_TR1]); // R8
		t0_res    = dtwt_step(state_reg.t0_mode, state_reg.t0_high, state_reg.t0_low);
		t1_res    = dtwt_step(state_reg.t1_mode, state_reg.t1_high, state_reg.t1_low);
		th0_res   = {1'b0, state_reg.t0_high} + 9'h001;
		wt_tick   = state_reg.wt_cfg[dtwt_pkg::WC_EN] & (state_reg.wt_cfg[dtwt_pkg::WC_CSEL]
		            ? (i_crystal_clock & ~state_reg.crystal_clock_last & ~state_reg.wt_pwr[dtwt_pkg::PW_CRYSTAL_CLOCK])
		            : (i_low_speed_rc_clock & ~state_reg.rc_last)); // R14 R15
		wt_target = state_reg.wt_cfg[dtwt_pkg::WC_STEP]
		            ? {state_reg.wt_set_high, state_reg.wt_set_low, 16'hffff}
		            : {16'h0000, state_reg.wt_set_high, state_reg.wt_set_low}; // R16 R17
		wt_wr     = wr_main & ((i_sfr_addr == dtwt_pkg::ADDR_WT_CFG) | (i_sfr_addr == dtwt_pkg::ADDR_WT_SETH)
		            | (i_sfr_addr == dtwt_pkg::ADDR_WT_SETL));
		wt_match  = wt_tick & ~wt_wr & (state_reg.wt_cnt == wt_target); // R13
		wr_t0     = wr_main & ((i_sfr_addr == dtwt_pkg::ADDR_T0_LOW) | (i_sfr_addr == dtwt_pkg::ADDR_T0_HIGH));
		wr_t1     = wr_main & ((i_sfr_addr == dtwt_pkg::ADDR_T1_LOW) | (i_sfr_addr == dtwt_pkg::ADDR_T1_HIGH));
		wr_tctrl  = wr_main & (i_sfr_addr == dtwt_pkg::ADDR_TCTRL);
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		state_next           = state_reg;
		state_next.presc     = tick ? 4'h0 : state_reg.presc + 4'h1; // R2
		state_next.rc_last   = i_low_speed_rc_clock;
		state_next.crystal_clock_last = i_crystal_clock;

		// Counting first; a software write in the same cycle overrides the count.
		if (t0_run)
		begin
			state_next.t0_low = t0_res[7:0];
			if (!split)
			begin
				state_next.t0_high = t0_res[15:8];
			end
		end
		if (th0_run)
		begin
			state_next.t0_high = th0_res[7:0]; // R7
		end
		if (t1_run)
		begin
			state_next.t1_low  = t1_res[7:0];
			state_next.t1_high = t1_res[15:8];
		end

		if (wr_main)
		begin
			case (i_sfr_addr)
				dtwt_pkg::ADDR_TCTRL:   state_next.tctrl = i_sfr_wdata;
				dtwt_pkg::ADDR_TMODE:
				begin
					state_next.t0_mode = i_sfr_wdata[dtwt_pkg::TM_M0LO +: 2]; // R12
					state_next.t1_mode = i_sfr_wdata[dtwt_pkg::TM_M1LO +: 2]; // R12
				end
				dtwt_pkg::ADDR_T0_LOW:  state_next.t0_low = i_sfr_wdata;
				dtwt_pkg::ADDR_T0_HIGH: state_next.t0_high = i_sfr_wdata;
				dtwt_pkg::ADDR_T1_LOW:  state_next.t1_low = i_sfr_wdata;
				dtwt_pkg::ADDR_T1_HIGH: state_next.t1_high = i_sfr_wdata;
				dtwt_pkg::ADDR_WT_CFG:  state_next.wt_cfg = i_sfr_wdata[3:0];
				dtwt_pkg::ADDR_WT_SETH: state_next.wt_set_high = i_sfr_wdata;
				dtwt_pkg::ADDR_WT_SETL: state_next.wt_set_low = i_sfr_wdata;
				default:                state_next.rdata = state_reg.rdata;
			endcase
		end
		if (i_sfr_wr && i_sfr_sec && (i_sfr_addr == dtwt_pkg::ADDR_WT_PWR))
		begin
			state_next.wt_pwr = i_sfr_wdata;
		end

		// Hardware set wins over a software clear in the same cycle.
		state_next.tctrl[dtwt_pkg::TC_TF0] = state_next.tctrl[dtwt_pkg::TC_TF0] | (t0_run & t0_res[16]); // R10
		state_next.tctrl[dtwt_pkg::TC_TF1] = state_next.tctrl[dtwt_pkg::TC_TF1]
		                                     | (split ? (th0_run & th0_res[8]) : (t1_run & t1_res[16])); // R9 R10
		state_next.tctrl[dtwt_pkg::TC_EI0] = state_next.tctrl[dtwt_pkg::TC_EI0] | i_ext_irq_zero_evt; // R11
		state_next.tctrl[dtwt_pkg::TC_EI1] = state_next.tctrl[dtwt_pkg::TC_EI1] | i_ext_irq_one_evt; // R11

		// Wake-up timer counting and completion.
		if (wt_wr)
		begin
			state_next.wt_cnt = 32'h0000_0000; // R18
		end
		else if (wt_match)
		begin
			state_next.wt_cnt = 32'h0000_0000; // R16
			if (!state_reg.wt_cfg[dtwt_pkg::WC_RLD])
			begin
				state_next.wt_cfg[dtwt_pkg::WC_EN] = 1'b0; // R20
			end
		end
		else if (wt_tick)
		begin
			state_next.wt_cnt = state_reg.wt_cnt + 32'h0000_0001; // R13
		end
		state_next.wt_flag = (state_reg.wt_flag & ~i_wake_flag_clr) | wt_match; // R19 R23

		// Read data is captured on the strobe; unmapped addresses read zero.
		if (i_sfr_rd)
		begin
			state_next.rdata = 8'h00;
			if (i_sfr_sec)
			begin
				if (i_sfr_addr == dtwt_pkg::ADDR_WT_PWR)
				begin
					state_next.rdata = state_reg.wt_pwr;
				end
			end
			else
			begin
				case (i_sfr_addr)
					dtwt_pkg::ADDR_TCTRL:   state_next.rdata = state_reg.tctrl | dtwt_pkg::TCTRL_RSVD;
					dtwt_pkg::ADDR_TMODE:   state_next.rdata = {2'h0, state_reg.t1_mode, 2'h0, state_reg.t0_mode};
					dtwt_pkg::ADDR_T0_LOW:  state_next.rdata = state_reg.t0_low;
					dtwt_pkg::ADDR_T0_HIGH: state_next.rdata = state_reg.t0_high;
					dtwt_pkg::ADDR_T1_LOW:  state_next.rdata = state_reg.t1_low;
					dtwt_pkg::ADDR_T1_HIGH: state_next.rdata = state_reg.t1_high;
					dtwt_pkg::ADDR_WT_CFG:  state_next.rdata = {4'h0, state_reg.wt_cfg};
					dtwt_pkg::ADDR_WT_SETH: state_next.rdata = state_reg.wt_set_high;
					dtwt_pkg::ADDR_WT_SETL: state_next.rdata = state_reg.wt_set_low;
					default:                state_next.rdata = 8'h00;
				endcase
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_reg             <= '0;
			state_reg.tctrl       <= dtwt_pkg::RST_BYTE;
			state_reg.t0_low      <= dtwt_pkg::RST_BYTE;
			state_reg.t0_high     <= dtwt_pkg::RST_BYTE;
			state_reg.t1_low      <= dtwt_pkg::RST_BYTE;
			state_reg.t1_high     <= dtwt_pkg::RST_BYTE;
			state_reg.wt_set_high <= dtwt_pkg::RST_BYTE;
			state_reg.wt_set_low  <= dtwt_pkg::RST_BYTE;
			state_reg.wt_pwr      <= dtwt_pkg::RST_PWR;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign o_sfr_rdata                 = state_reg.rdata;
	assign o_timer_zero_overflow_flag  = state_reg.tctrl[dtwt_pkg::TC_TF0];
	assign o_timer_one_overflow_flag   = state_reg.tctrl[dtwt_pkg::TC_TF1];
	assign o_ext_irq_zero_flag         = state_reg.tctrl[dtwt_pkg::TC_EI0];
	assign o_ext_irq_one_flag          = state_reg.tctrl[dtwt_pkg::TC_EI1];
	assign o_wake_timer_flag           = state_reg.wt_flag;
	assign o_wake_request              = state_reg.wt_flag; // R19 R23
	assign o_wake_timer_power_switches = state_reg.wt_pwr;

	// ************************************************************
	// Checks
	// ************************************************************
	a_prescale_spacing: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R2
		tick |-> ##12 tick)
		else $error("prescale tick not twelve cycles apart");

	a_mode0_wrap: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R3
		(t0_run && !split && state_reg.t0_mode == dtwt_pkg::MODE_13 && !wr_t0 && !wr_main
		 && state_reg.t0_high == 8'hff && state_reg.t0_low[4:0] == 5'h1f)
		|=> (state_reg.t0_high == 8'h00 && state_reg.t0_low[4:0] == 5'h00
		 && state_reg.t0_low[7:5] == $past(state_reg.t0_low[7:5]) && state_reg.tctrl[dtwt_pkg::TC_TF0]))
		else $error("mode 0 wrap wrong");

	a_mode1_wrap: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R4
		(t1_run && !split && state_reg.t1_mode == dtwt_pkg::MODE_16 && !wr_main
		 && {state_reg.t1_high, state_reg.t1_low} == 16'hffff)
		|=> ({state_reg.t1_high, state_reg.t1_low} == 16'h0000 && state_reg.tctrl[dtwt_pkg::TC_TF1]))
		else $error("mode 1 wrap wrong");

	a_mode2_reload: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R22
		(t0_run && state_reg.t0_mode == dtwt_pkg::MODE_RLD && !wr_main && state_reg.t0_low == 8'hff)
		|=> (state_reg.t0_low == $past(state_reg.t0_high) && state_reg.t0_high == $past(state_reg.t0_high)
		 && state_reg.tctrl[dtwt_pkg::TC_TF0]))
		else $error("mode 2 reload wrong");

	a_split_high: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R7
		(th0_run && !wr_main && state_reg.t0_high == 8'hff) |=> state_reg.tctrl[dtwt_pkg::TC_TF1])
		else $error("split high byte overflow lost");

	a_timer1_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R8
		(split && state_reg.t1_mode == dtwt_pkg::MODE_SPL && !wr_t1) |=> $stable(state_reg.t1_low))
		else $error("timer one moved in mode 3");

	a_ext_flag_set: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R11
		i_ext_irq_one_evt |=> o_ext_irq_one_flag)
		else $error("external flag not set");

	a_wake_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R18
		wt_wr |=> state_reg.wt_cnt == 32'h0000_0000)
		else $error("wake counter not cleared on write");

	a_wake_oneshot: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R20
		(wt_match && !state_reg.wt_cfg[dtwt_pkg::WC_RLD] && !wr_main)
		|=> (!state_reg.wt_cfg[dtwt_pkg::WC_EN] && o_wake_timer_flag)
		##1 ((!state_reg.wt_cfg[dtwt_pkg::WC_EN] && o_wake_timer_flag) || $past(wr_main || i_wake_flag_clr)))
		else $error("single shot did not stop");

	a_ext_zero_set: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R11
		i_ext_irq_zero_evt |=> o_ext_irq_zero_flag)
		else $error("external flag zero not set");

	a_ext_one_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R11
		(o_ext_irq_one_flag && !wr_tctrl) |=> o_ext_irq_one_flag)
		else $error("external flag one cleared by hardware");

	a_ext_zero_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R11
		(o_ext_irq_zero_flag && !wr_tctrl) |=> o_ext_irq_zero_flag)
		else $error("external flag zero cleared by hardware");

	a_overflow_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R10
		(o_timer_zero_overflow_flag && !wr_tctrl) |=> o_timer_zero_overflow_flag)
		else $error("overflow flag cleared by hardware");

	a_run_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R2
		(!state_reg.tctrl[dtwt_pkg::TC_TR0] && !wr_t0) |=> $stable(state_reg.t0_low))
		else $error("timer zero moved while stopped");

	a_mode0_top_bits: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R1
		(t0_run && state_reg.t0_mode == dtwt_pkg::MODE_13 && !wr_t0) |=> $stable(state_reg.t0_low[7:5]))
		else $error("mode 0 touched the top low bits");

	a_split_high_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R6
		(split && !th0_run && !wr_t0) |=> $stable(state_reg.t0_high))
		else $error("split high byte moved without its run bit");

	a_split_no_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R9
		(split && !th0_run && !o_timer_one_overflow_flag && !wr_tctrl) |=> !o_timer_one_overflow_flag)
		else $error("timer one flag set by timer one in split mode");

	a_wake_match_set: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R13 R16
		wt_match |=> (o_wake_timer_flag && state_reg.wt_cnt == 32'h0000_0000))
		else $error("wake match did not set flag and restart");

	a_wake_flag_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R23
		(o_wake_timer_flag && !i_wake_flag_clr) |=> o_wake_timer_flag)
		else $error("wake flag dropped without a clear");

	a_wake_idle_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R15
		(!state_reg.wt_cfg[dtwt_pkg::WC_EN] && !wt_wr) |=> $stable(state_reg.wt_cnt))
		else $error("wake counter moved while disabled");

endmodule

`default_nettype wire

/* File: testbench/dtwt_tb.sv */
// Self-checking bench for the dual basic timer and wake-up timer block.
// Assumes the design answers reads one cycle after the strobe and samples the slow clocks on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       i_mclk;
	logic       i_resetn;
	logic       i_sfr_sec;
	logic [7:0] i_sfr_addr;
	logic       i_sfr_wr;
	logic       i_sfr_rd;
	logic [7:0] i_sfr_wdata;
	logic       i_ext_irq_zero_evt;
	logic       i_ext_irq_one_evt;
	logic       i_low_speed_rc_clock;
	logic       i_crystal_clock;
	logic       i_wake_flag_clr;
	logic [7:0] o_sfr_rdata;
	logic       o_timer_zero_overflow_flag;
	logic       o_timer_one_overflow_flag;
	logic       o_ext_irq_zero_flag;
	logic       o_ext_irq_one_flag;
	logic       o_wake_timer_flag;
	logic       o_wake_request;
	logic [7:0] o_wake_timer_power_switches;
	int         miscompares;
	int         check_count;
	int         n;
	logic [7:0] d;
	logic [7:0] e;
	logic [7:0] reg_addr [9];
	logic [7:0] reg_rst  [9];

	dtwt_timer DUT
	(
		.i_mclk                      (i_mclk),
		.i_resetn                    (i_resetn),
		.i_sfr_sec                   (i_sfr_sec),
		.i_sfr_addr                  (i_sfr_addr),
		.i_sfr_wr                    (i_sfr_wr),
		.i_sfr_rd                    (i_sfr_rd),
		.i_sfr_wdata                 (i_sfr_wdata),
		.o_sfr_rdata                 (o_sfr_rdata),
		.i_ext_irq_zero_evt          (i_ext_irq_zero_evt),
		.i_ext_irq_one_evt           (i_ext_irq_one_evt),
		.i_low_speed_rc_clock        (i_low_speed_rc_clock),
		.i_crystal_clock             (i_crystal_clock),
		.i_wake_flag_clr             (i_wake_flag_clr),
		.o_timer_zero_overflow_flag  (o_timer_zero_overflow_flag),
		.o_timer_one_overflow_flag   (o_timer_one_overflow_flag),
		.o_ext_irq_zero_flag         (o_ext_irq_zero_flag),
		.o_ext_irq_one_flag          (o_ext_irq_one_flag),
		.o_wake_timer_flag           (o_wake_timer_flag),
		.o_wake_request              (o_wake_request),
		.o_wake_timer_power_switches (o_wake_timer_power_switches)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	// ************************************************************
	// Access tasks; each is entered and left 1 ns after a rising edge.
	// A quiet cycle closes each access, so the next call never re-raises a strobe in the same time step.
	// ************************************************************
	task automatic end_sim();
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
		check_count++;
		if (got !== ex)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic sec, input logic [7:0] a, input logic [7:0] v);
		i_sfr_sec = sec;
		i_sfr_addr = a;
		i_sfr_wdata = v;
		i_sfr_wr = 1'b1;
		@(posedge i_mclk);
		#1;
		i_sfr_wr = 1'b0;
		i_sfr_sec = 1'b0;
		@(posedge i_mclk);
		#1;
	endtask

	task automatic rd(input logic sec, input logic [7:0] a, output logic [7:0] v);
		i_sfr_sec = sec;
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		@(posedge i_mclk);
		#1;
		i_sfr_rd = 1'b0;
		i_sfr_sec = 1'b0;
		v = o_sfr_rdata;
		@(posedge i_mclk);
		#1;
	endtask

	function automatic logic sel_flag(input int w);
		return (w == 0) ? o_timer_zero_overflow_flag : (w == 1) ? o_timer_one_overflow_flag : o_wake_timer_flag;
	endfunction

	// Polls a flag for at most 60 cycles and returns the number of edges waited.
	task automatic wait_flag(input int w, output int cnt);
		cnt = 0;
		while (sel_flag(w) !== 1'b1 && cnt < 60)
		begin
			@(posedge i_mclk);
			#1;
			cnt++;
		end
		if (cnt == 60)
		begin
			miscompares++;
			$display("MISMATCH flag %0d expected 1 seen 0", w);
			end_sim();
		end
	endtask

	// One slow-clock period: three system cycles high, three low.
	task automatic tick(input logic crystal_clock);
		i_crystal_clock = crystal_clock;
		i_low_speed_rc_clock = ~crystal_clock;
		repeat (3) @(posedge i_mclk);
		#1;
		i_crystal_clock = 1'b0;
		i_low_speed_rc_clock = 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask

	task automatic clr_wake();
		i_wake_flag_clr = 1'b1;
		@(posedge i_mclk);
		#1;
		i_wake_flag_clr = 1'b0;
		chk8("wake flag cleared", 8'h00, {7'h00, o_wake_timer_flag});
	endtask

	task automatic basic(input logic [7:0] md, ha, la, hv, lv, run, input int w, input logic [7:0] eh, el);
		wr(1'b0, dtwt_pkg::ADDR_TCTRL, 8'h00);
		wr(1'b0, dtwt_pkg::ADDR_TMODE, md);
		wr(1'b0, ha, hv);
		wr(1'b0, la, lv);
		wr(1'b0, dtwt_pkg::ADDR_TCTRL, run);
		wait_flag(w, n);
		rd(1'b0, ha, d);
		chk8("count high", eh, d);
		rd(1'b0, la, d);
		chk8("count low", el, d);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		{i_resetn, i_sfr_sec, i_sfr_wr, i_sfr_rd, i_ext_irq_zero_evt, i_ext_irq_one_evt} = 6'h00;
		{i_low_speed_rc_clock, i_crystal_clock, i_wake_flag_clr} = 3'h0;
		i_sfr_addr = 8'h00;
		i_sfr_wdata = 8'h00;
		miscompares = 0;
		check_count = 0;
		reg_addr = '{dtwt_pkg::ADDR_TCTRL, dtwt_pkg::ADDR_TMODE, dtwt_pkg::ADDR_T0_LOW, dtwt_pkg::ADDR_T1_LOW,
			dtwt_pkg::ADDR_T0_HIGH, dtwt_pkg::ADDR_T1_HIGH, dtwt_pkg::ADDR_WT_CFG, dtwt_pkg::ADDR_WT_SETH,
			dtwt_pkg::ADDR_WT_SETL};
		reg_rst = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (10) @(posedge i_mclk);
		#1;
		i_resetn = 1'b1;
		for (int k = 0; k < 9; k++)
		begin
			rd(1'b0, reg_addr[k], d);
			chk8("reset value", reg_rst[k], d);
		end
		rd(1'b1, dtwt_pkg::ADDR_WT_PWR, d);
		chk8("power reset", 8'hff, d);
		rd(1'b0, 8'h90, d);
		chk8("unmapped read", 8'h00, d);
		rd(1'b1, dtwt_pkg::ADDR_TCTRL, d);
		chk8("secondary unmapped", 8'h00, d);
		// External event flags set by hardware, held until a control write clears them.
		i_ext_irq_zero_evt = 1'b1;
		i_ext_irq_one_evt = 1'b1;
		@(posedge i_mclk);
		#1;
		i_ext_irq_zero_evt = 1'b0;
		i_ext_irq_one_evt = 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
		chk8("ext flags", 8'h03, {6'h00, o_ext_irq_one_flag, o_ext_irq_zero_flag});
		rd(1'b0, dtwt_pkg::ADDR_TCTRL, d);
		chk8("control ext", 8'h0f, d);
		wr(1'b0, dtwt_pkg::ADDR_TCTRL, 8'h00);
		rd(1'b0, dtwt_pkg::ADDR_TCTRL, d);
		chk8("control cleared", 8'h05, d);
		basic(8'h00, dtwt_pkg::ADDR_T0_HIGH, dtwt_pkg::ADDR_T0_LOW, 8'hff, 8'hff, 8'h10, 0, 8'h00, 8'he0);
		basic(8'h10, dtwt_pkg::ADDR_T1_HIGH, dtwt_pkg::ADDR_T1_LOW, 8'hff, 8'hff, 8'h40, 1, 8'h00, 8'h00);
		basic(8'h02, dtwt_pkg::ADDR_T0_HIGH, dtwt_pkg::ADDR_T0_LOW, 8'hff, 8'hff, 8'h10, 0, 8'hff, 8'hff);
		wr(1'b0, dtwt_pkg::ADDR_TCTRL, 8'h10);
		wait_flag(0, n);
		chk8("tick spacing", 8'h06, 8'(n));
		wr(1'b0, dtwt_pkg::ADDR_TCTRL, 8'h00);
		wr(1'b0, dtwt_pkg::ADDR_T1_LOW, 8'h1f);
		wr(1'b0, dtwt_pkg::ADDR_T1_HIGH, 8'h00);
		basic(8'h03, dtwt_pkg::ADDR_T0_HIGH, dtwt_pkg::ADDR_T0_LOW, 8'hff, 8'h55, 8'h40, 1, 8'h00, 8'h55);
		chk8("split zero flag", 8'h00, {7'h00, o_timer_zero_overflow_flag});
		rd(1'b0, dtwt_pkg::ADDR_T1_HIGH, d);
		chk8("split timer one runs", 8'h01, d);
		wr(1'b0, dtwt_pkg::ADDR_TMODE, 8'hff);
		rd(1'b0, dtwt_pkg::ADDR_TMODE, d);
		chk8("mode fields", 8'h33, d);
		rd(1'b0, dtwt_pkg::ADDR_T1_LOW, e);
		repeat (30) @(posedge i_mclk);
		#1;
		rd(1'b0, dtwt_pkg::ADDR_T1_LOW, d);
		chk8("timer one held", e, d);
		wr(1'b0, dtwt_pkg::ADDR_TCTRL, 8'h00);
		// Wake timer single shot with setting 1: two ticks per period.
		wr(1'b0, dtwt_pkg::ADDR_WT_SETH, 8'h00);
		wr(1'b0, dtwt_pkg::ADDR_WT_SETL, 8'h01);
		wr(1'b0, dtwt_pkg::ADDR_WT_CFG, 8'h01);
		tick(1'b0);
		chk8("wake early", 8'h00, {7'h00, o_wake_timer_flag});
		tick(1'b0);
		chk8("wake match", 8'h03, {6'h00, o_wake_request, o_wake_timer_flag});
		rd(1'b0, dtwt_pkg::ADDR_WT_CFG, d);
		chk8("single shot enable", 8'h00, d);
		chk8("wake flag held", 8'h01, {7'h00, o_wake_timer_flag});
		clr_wake();
		wr(1'b0, dtwt_pkg::ADDR_WT_CFG, 8'h03);
		tick(1'b0);
		wr(1'b0, dtwt_pkg::ADDR_WT_SETL, 8'h01);
		tick(1'b0);
		chk8("counter cleared", 8'h00, {7'h00, o_wake_timer_flag});
		tick(1'b0);
		chk8("reload match", 8'h01, {7'h00, o_wake_timer_flag});
		rd(1'b0, dtwt_pkg::ADDR_WT_CFG, d);
		chk8("reload enable kept", 8'h03, d);
		clr_wake();
		wr(1'b0, dtwt_pkg::ADDR_WT_CFG, 8'h00);
		// Crystal source once its power switch is opened.
		wr(1'b1, dtwt_pkg::ADDR_WT_PWR, 8'hef);
		chk8("power switches", 8'hef, o_wake_timer_power_switches);
		wr(1'b0, dtwt_pkg::ADDR_WT_SETL, 8'h00);
		wr(1'b0, dtwt_pkg::ADDR_WT_CFG, 8'h05);
		tick(1'b0);
		chk8("rc ignored", 8'h00, {7'h00, o_wake_timer_flag});
		tick(1'b1);
		chk8("crystal match", 8'h01, {7'h00, o_wake_timer_flag});
		rd(1'b0, dtwt_pkg::ADDR_WT_CFG, d);
		chk8("crystal single shot", 8'h04, d);
		clr_wake();
		wr(1'b0, dtwt_pkg::ADDR_WT_CFG, 8'hfe);
		rd(1'b0, dtwt_pkg::ADDR_WT_CFG, d);
		chk8("config fields", 8'h0e, d);
		end_sim();
	end
endmodule
`default_nettype wire
